// *** pwmt_top.sv ***
/*
 * pwmt_top: primary pwm time base control with an AXI4-Lite register slave,
 * time base counter, period buffering, special event postscaler, external
 * sync in and out, and a masked sticky interrupt.
 * assumes cpu_idle comes from logic on aclk; sync inputs are raw pins.
 */
// Notes on behaviour
// - top control bit enables module, reset zero
// - idle-stop bit halts time base in idle
// - special event pending set by hardware, cleared by a write of one to status
// - bit eleven enables special event interrupt
// - period updates immediate or deferred to rollover
// - polarity bit makes sync in/out active-low
// - bit eight enables the sync output
// - bit seven enables external time base sync
// - source field picks sync input; rest reserved
module pwmt_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    // axi4-lite write response
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    // axi4-lite read data
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu state
    input  wire logic        cpu_idle,
    // sync pins
    input  wire logic        sync_input_one,
    input  wire logic        sync_input_two,
    output      logic        sync_output_one,
    output      logic        sync_output_one_oe,
    // interrupts and status
    output      logic        irq,
    output      logic        special_event_irq,
    output      logic [15:0] tb_count
);

    pwmt_pkg::pwmt_ctrl_t ctrl_reg;
    logic [15:0]          period_buf_reg;
    logic [15:0]          period_act_reg;
    logic [15:0]          evt_cmp_reg;
    logic [15:0]          count_reg;
    logic [3:0]           post_cnt_reg;
    logic [2:0]           irq_stat_reg;
    logic [2:0]           irq_mask_reg;
    logic                 sync_lvl_d_reg;
    logic [1:0]           sync_pins;

    // write channel state
    logic                 have_aw_reg;
    logic                 have_w_reg;
    logic [7:0]           awaddr_reg;
    logic [31:0]          wdata_reg;
    logic [3:0]           wstrb_reg;
    logic                 aw_fire;
    logic                 w_fire;
    logic                 do_write;
    logic                 ar_fire;

    // decoded writes
    logic                 wr_ctrl;
    logic                 wr_period;
    logic                 wr_cmp;
    logic                 wr_stat;
    logic                 wr_mask;
    logic                 wr_hit;

    // time base terms
    logic                 enabled;
    logic                 halted;
    logic                 tick;
    logic                 sync_sel;
    logic                 sync_lvl;
    logic                 sync_hit;
    logic                 rollover;
    logic                 cmp_match;
    logic                 se_fire;
    logic [15:0]          period_wval;

    logic [31:0]          rd_data;
    logic                 rd_err;

    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] r;
        r = old_v;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    pwmt_sync2 #(
        .WIDTH (2)
    ) u_sync_in (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({sync_input_two, sync_input_one}),
        .sync_out (sync_pins)
    );

    // bus handshakes
    assign aw_fire  = s_axi_awvalid && s_axi_awready;
    assign w_fire   = s_axi_wvalid && s_axi_wready;
    assign do_write = have_aw_reg && have_w_reg && !s_axi_bvalid;
    assign ar_fire  = s_axi_arvalid && s_axi_arready;

    assign wr_ctrl   = do_write && (awaddr_reg == pwmt_pkg::OFF_CTRL);
    assign wr_period = do_write && (awaddr_reg == pwmt_pkg::OFF_PERIOD);
    assign wr_cmp    = do_write && (awaddr_reg == pwmt_pkg::OFF_EVT_CMP);
    assign wr_stat   = do_write && (awaddr_reg == pwmt_pkg::OFF_IRQ_STAT);
    assign wr_mask   = do_write && (awaddr_reg == pwmt_pkg::OFF_IRQ_MASK);
    assign wr_hit    = wr_ctrl || wr_period || wr_cmp || wr_stat || wr_mask ||
                       (awaddr_reg == pwmt_pkg::OFF_COUNT);

    assign period_wval = merge16(period_buf_reg, wdata_reg, wstrb_reg);

    // time base control terms
    assign enabled = ctrl_reg.module_enable_bit;
    assign halted  = ctrl_reg.idle_stop_bit && cpu_idle;
    assign tick    = enabled && !halted;

    // reserved source codes select nothing
    always_comb begin
        case (ctrl_reg.sync_source_select)
            pwmt_pkg::SRC_INPUT_ONE: sync_sel = sync_pins[0];
            pwmt_pkg::SRC_INPUT_TWO: sync_sel = sync_pins[1];
            default:                 sync_sel = 1'b0;
        endcase
    end

    assign sync_lvl = (sync_sel ^ ctrl_reg.sync_polarity_invert) &&
                      ctrl_reg.sync_source_select <= pwmt_pkg::SRC_INPUT_TWO;
    // restart on the leading edge of an asserted external sync
    assign sync_hit = enabled && ctrl_reg.ext_sync_enable && sync_lvl && !sync_lvl_d_reg;
    // a period shorter than the sync spacing would roll over on its own
    assign rollover  = tick && !sync_hit && (count_reg >= period_act_reg);
    assign cmp_match = tick && (count_reg == evt_cmp_reg);
    assign se_fire   = cmp_match && (post_cnt_reg == ctrl_reg.event_postscale);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_lvl_d_reg <= 1'b0;
        end else begin
            sync_lvl_d_reg <= sync_lvl;
        end
    end

    // control register; the pending bit lives in the status register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= pwmt_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= merge16(ctrl_reg, wdata_reg, wstrb_reg) & pwmt_pkg::CTRL_WR_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_cmp_reg <= pwmt_pkg::EVT_CMP_RST;
        end else if (wr_cmp) begin
            evt_cmp_reg <= merge16(evt_cmp_reg, wdata_reg, wstrb_reg);
        end
    end

    // period buffer and active period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_buf_reg <= pwmt_pkg::PERIOD_RST;
            period_act_reg <= pwmt_pkg::PERIOD_RST;
        end else begin
            if (wr_period) begin
                period_buf_reg <= period_wval;
            end
            if (wr_period && (ctrl_reg.immediate_period_update || !enabled)) begin
                period_act_reg <= period_wval;
            end else if (rollover || !enabled) begin
                period_act_reg <= period_buf_reg;
            end
        end
    end

    // time base counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
        end else if (!enabled) begin
            count_reg <= '0;
        end else if (sync_hit || rollover) begin
            count_reg <= '0;
        end else if (!halted) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // postscaler counts compare matches; meaning of the field is a guess
    always_ff @(posedge aclk) begin
        if (!aresetn || !enabled) begin
            post_cnt_reg <= '0;
        end else if (se_fire) begin
            post_cnt_reg <= '0;
        end else if (cmp_match) begin
            post_cnt_reg <= post_cnt_reg + 4'h1;
        end
    end

    // sticky status, write one to clear, a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= pwmt_pkg::IRQ_RST;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wdata_reg[2:0] & {3{wstrb_reg[0]}} : 3'h0)) |
                            {sync_hit, rollover, se_fire};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= pwmt_pkg::IRQ_RST;
        end else if (wr_mask && wstrb_reg[0]) begin
            irq_mask_reg <= wdata_reg[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq               <= 1'b0;
            special_event_irq <= 1'b0;
            tb_count          <= '0;
        end else begin
            irq               <= |(irq_stat_reg & irq_mask_reg);
            special_event_irq <= irq_stat_reg[pwmt_pkg::IRQ_SPECIAL] &&
                                 ctrl_reg.special_event_irq_enable;
            tb_count          <= count_reg;
        end
    end

    // sync output pulses at rollover; idles at the inactive level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_output_one    <= 1'b0;
            sync_output_one_oe <= 1'b0;
        end else begin
            sync_output_one_oe <= ctrl_reg.sync_output_enable;
            sync_output_one    <= (ctrl_reg.sync_output_enable && rollover) ^
                                  ctrl_reg.sync_polarity_invert;
        end
    end

    // write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw_reg   <= 1'b0;
            have_w_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pwmt_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                have_aw_reg   <= 1'b1;
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!have_aw_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (w_fire) begin
                have_w_reg   <= 1'b1;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!have_w_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                have_aw_reg  <= 1'b0;
                have_w_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? pwmt_pkg::RESP_OKAY : pwmt_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux; the pending bit shows the special event status
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        case (s_axi_araddr)
            pwmt_pkg::OFF_CTRL: begin
                rd_data[15:0] = ctrl_reg;
                rd_data[pwmt_pkg::BIT_PENDING] = irq_stat_reg[pwmt_pkg::IRQ_SPECIAL];
            end
            pwmt_pkg::OFF_PERIOD:   rd_data[15:0] = period_buf_reg;
            pwmt_pkg::OFF_EVT_CMP:  rd_data[15:0] = evt_cmp_reg;
            pwmt_pkg::OFF_COUNT:    rd_data[15:0] = count_reg;
            pwmt_pkg::OFF_IRQ_STAT: rd_data[2:0]  = irq_stat_reg;
            pwmt_pkg::OFF_IRQ_MASK: rd_data[2:0]  = irq_mask_reg;
            default:                rd_err        = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= pwmt_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? pwmt_pkg::RESP_SLVERR : pwmt_pkg::RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_disabled_zero;
        !ctrl_reg.module_enable_bit |=> count_reg == 16'h0000 ##1 tb_count == 16'h0000;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) else $error("count not held at zero while disabled");

    property p_idle_halt;
        enabled && ctrl_reg.idle_stop_bit && cpu_idle && !sync_hit |=> $stable(count_reg);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("time base moved during idle stop");

    property p_idle_run;
        enabled && !ctrl_reg.idle_stop_bit && !sync_hit && count_reg < period_act_reg
            |=> count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("time base did not advance");

    property p_pending_set;
        se_fire |=> irq_stat_reg[pwmt_pkg::IRQ_SPECIAL] ##1 irq_stat_reg[pwmt_pkg::IRQ_SPECIAL] || $past(wr_stat);
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("special event not pending after event");

    property p_irq_gate;
        !ctrl_reg.special_event_irq_enable [*2] |-> !special_event_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("special irq raised while disabled");

    property p_irq_raise;
        irq_stat_reg[pwmt_pkg::IRQ_SPECIAL] && ctrl_reg.special_event_irq_enable |=> special_event_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("special irq not raised");

    property p_period_now;
        wr_period && ctrl_reg.immediate_period_update |=> period_act_reg == period_buf_reg;
    endproperty
    a_period_now: assert property (p_period_now) else $error("immediate period update not applied");

    property p_period_defer;
        enabled && !ctrl_reg.immediate_period_update && !rollover |=> $stable(period_act_reg);
    endproperty
    a_period_defer: assert property (p_period_defer) else $error("deferred period changed early");

    property p_out_off;
        !ctrl_reg.sync_output_enable |=> !sync_output_one_oe && sync_output_one == $past(ctrl_reg.sync_polarity_invert);
    endproperty
    a_out_off: assert property (p_out_off) else $error("sync output active while disabled");

    property p_sync_edge;
        sync_hit |-> (sync_sel ^ ctrl_reg.sync_polarity_invert) && !sync_lvl_d_reg ##1 count_reg == 16'h0000;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("sync restart without asserted edge");

    property p_sync_off;
        !ctrl_reg.ext_sync_enable || ctrl_reg.sync_source_select > pwmt_pkg::SRC_INPUT_TWO |-> !sync_hit;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync applied while disabled or reserved");

endmodule

// *** pwmt_pkg.sv ***
/*
 * pwmt_pkg: register map, field layout, reset values and bus codes of the
 * primary pwm time base control block.
 * assumes a 32-bit AXI4-Lite slave with an 8-bit byte address.
 */
package pwmt_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 16;

    // byte addresses, one aligned word per register
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PERIOD   = 8'h04;
    localparam logic [7:0] OFF_EVT_CMP  = 8'h08;
    localparam logic [7:0] OFF_COUNT    = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // control register bit positions
    localparam int unsigned BIT_ENABLE    = 15;
    localparam int unsigned BIT_IDLE_STOP = 13;
    localparam int unsigned BIT_PENDING   = 12;

    // control bits that software may write; 14 and 12 are not
    localparam logic [15:0] CTRL_WR_MASK = 16'hAFFF;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] PERIOD_RST   = 16'hFFFF;
    localparam logic [15:0] EVT_CMP_RST  = 16'h0000;

    // sync source codes
    localparam logic [2:0] SRC_INPUT_ONE = 3'h0;
    localparam logic [2:0] SRC_INPUT_TWO = 3'h1;

    // interrupt status and mask layout
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_SPECIAL  = 0;
    localparam int unsigned IRQ_ROLLOVER = 1;
    localparam int unsigned IRQ_SYNC     = 2;
    localparam logic [2:0]  IRQ_RST      = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       module_enable_bit;
        logic       unused_14;
        logic       idle_stop_bit;
        logic       special_event_pending;
        logic       special_event_irq_enable;
        logic       immediate_period_update;
        logic       sync_polarity_invert;
        logic       sync_output_enable;
        logic       ext_sync_enable;
        logic [2:0] sync_source_select;
        logic [3:0] event_postscale;
    } pwmt_ctrl_t;

endpackage

// *** pwmt_sync2.sv ***
/*
 * pwmt_sync2: two flip-flop level synchroniser, one per bit.
 * assumes the inputs are asynchronous levels from pins.
 */
module pwmt_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// *** pwmt_sync_src.sv ***
/*
 * pwmt_sync_src: far-side source of the two sync input pins.
 * assumes fire strobes come from the bench on aclk, one cycle each.
 */
module pwmt_sync_src (
    // clock
    input  wire logic       aclk,
    // control from bench
    input  wire logic       pol,
    input  wire logic [1:0] fire,
    // pins
    output      logic       sync_input_one,
    output      logic       sync_input_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold_one = 3'h0;
    logic [2:0] hold_two = 3'h0;
    // pulse stands 4 cycles so the 2-flop synchroniser cannot miss it
    always_ff @(posedge aclk) begin
        hold_one <= fire[0] ? 3'h4 : (hold_one != 3'h0 ? hold_one - 3'h1 : 3'h0);
        hold_two <= fire[1] ? 3'h4 : (hold_two != 3'h0 ? hold_two - 3'h1 : 3'h0);
    end
    assign sync_input_one = (hold_one != 3'h0) ^ pol;
    assign sync_input_two = (hold_two != 3'h0) ^ pol;
endmodule

// *** testbench.sv ***
/*
 * testbench: register level regression of the pwm time base control block.
 * assumes the AXI4-Lite slave answers in its own time; waits are bounded.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, cpu_idle = 0, pol = 0;
    logic [1:0] fire = 2'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic s_one, s_two, s_out, s_oe, irq, se_irq;
    logic [15:0] tb_count, c0;
    logic [31:0] v;
    int n_errors = 0, checks_done = 0;
    always #4 aclk = ~aclk;
    pwmt_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_idle(cpu_idle), .sync_input_one(s_one), .sync_input_two(s_two),
        .sync_output_one(s_out), .sync_output_one_oe(s_oe),
        .irq(irq), .special_event_irq(se_irq), .tb_count(tb_count)
    );
    pwmt_sync_src i_src (
        .aclk(aclk), .pol(pol), .fire(fire),
        .sync_input_one(s_one), .sync_input_two(s_two)
    );
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic hang();
        n_errors++;
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; wstrb <= 4'hF; bready <= 1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (i == 100) hang();
        resp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (i == 100) hang();
        v = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    // bounded wait for an output level: 0 special irq, 1 irq, 2 sync out
    task automatic wait_lvl(input int which, input logic lvl);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (which == 0 && se_irq === lvl) break;
            if (which == 1 && irq === lvl) break;
            if (which == 2 && s_out === lvl) break;
        end
        if (i == 200) hang();
    endtask
    // configuration only ever changes with the module disabled first
    task automatic cfg(input logic [15:0] c);
        wr(pwmt_pkg::OFF_CTRL, 32'h0);
        wr(pwmt_pkg::OFF_CTRL, {16'h0, c});
    endtask
    task automatic sync_case(input logic [15:0] c, input logic p, input logic [1:0] f, input logic hit);
        cfg(16'h0000);
        pol <= p;
        wr(pwmt_pkg::OFF_IRQ_STAT, 32'h7);
        wr(pwmt_pkg::OFF_PERIOD, 32'hFFFF);
        cfg(c);
        repeat (100) @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 2'h0;
        repeat (8) @(posedge aclk);
        chk(tb_count < 16'h0008, hit);
        rd(pwmt_pkg::OFF_IRQ_STAT);
        chk(v[pwmt_pkg::IRQ_SYNC], hit);
    endtask
    task automatic period_case(input logic [15:0] c, input logic short);
        cfg(16'h0000);
        wr(pwmt_pkg::OFF_PERIOD, 32'hFFFF);
        cfg(c);
        repeat (50) @(posedge aclk);
        wr(pwmt_pkg::OFF_PERIOD, 32'h0007);
        repeat (20) @(posedge aclk);
        chk(tb_count <= 16'h0007, short);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(pwmt_pkg::OFF_CTRL);
        chk(v, 32'h0);
        rd(pwmt_pkg::OFF_PERIOD);
        chk(v, 32'hFFFF);
        rd(pwmt_pkg::OFF_IRQ_MASK);
        chk(v, 32'h0);
        rd(8'h20);
        chk(resp, pwmt_pkg::RESP_SLVERR);
        chk(v, 32'h0);
        wr(8'h20, 32'h1);
        chk(resp, pwmt_pkg::RESP_SLVERR);
        wr(pwmt_pkg::OFF_CTRL, 32'h5000);
        rd(pwmt_pkg::OFF_CTRL);
        chk(v, 32'h0);
        // special event: period 8 cycles, match at 3
        wr(pwmt_pkg::OFF_PERIOD, 32'h7);
        wr(pwmt_pkg::OFF_EVT_CMP, 32'h3);
        cfg(16'h8000);
        repeat (20) @(posedge aclk);
        chk(se_irq, 1'b0);
        rd(pwmt_pkg::OFF_CTRL);
        chk(v, 32'h9000);
        cfg(16'h8800);
        wait_lvl(0, 1'b1);
        wr(pwmt_pkg::OFF_IRQ_MASK, 32'h1);
        wait_lvl(1, 1'b1);
        wr(pwmt_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        cfg(16'h0800);
        wr(pwmt_pkg::OFF_IRQ_STAT, 32'h7);
        repeat (3) @(posedge aclk);
        chk(se_irq, 1'b0);
        rd(pwmt_pkg::OFF_CTRL);
        chk(v, 32'h0800);
        // idle halt and run
        cfg(16'hA000);
        cpu_idle <= 1;
        repeat (3) @(posedge aclk);
        c0 = tb_count;
        repeat (5) @(posedge aclk);
        chk(tb_count, c0);
        cfg(16'h8000);
        c0 = tb_count;
        repeat (3) @(posedge aclk);
        chk(tb_count !== c0, 1'b1);
        cpu_idle <= 0;
        // sync output enable and polarity
        cfg(16'h8100);
        // enable register lands one edge after the write response
        @(posedge aclk);
        chk(s_oe, 1'b1);
        wait_lvl(2, 1'b1);
        cfg(16'h8300);
        wait_lvl(2, 1'b0);
        cfg(16'h8000);
        chk(s_oe, 1'b0);
        // external sync restart, sources and polarity
        sync_case(16'h8000, 1'b0, 2'h1, 1'b0);
        sync_case(16'h8080, 1'b0, 2'h1, 1'b1);
        sync_case(16'h8090, 1'b0, 2'h2, 1'b1);
        sync_case(16'h80A0, 1'b0, 2'h3, 1'b0);
        sync_case(16'h8280, 1'b1, 2'h1, 1'b1);
        pol <= 0;
        // deferred then immediate period update
        period_case(16'h8000, 1'b0);
        period_case(16'h8400, 1'b1);
        cfg(16'h0000);
        chk(tb_count, 16'h0000);
        tally_and_finish();
    end
endmodule
